// ==== design/sas_pkg.sv ====
// Notes on behaviour
// - the input select reaches six sources: external channels 0 to 3, temperature 4, supply 5.
// - every conversion yields a 10-bit single-ended code of the selected input.
// - one conversion takes 20 sample-clock ticks, the tick running at 4 MHz.
// - external channels use one of eight divider scales from 1.00 down to 0.24.
// - absolute mode returns the code against the internal 950 mV full-scale reference.
// - ratio mode converts twice back to back and returns the first divided by the second.
// - pseudo-differential mode converts twice and returns the first minus the second.
// - ratio pseudo-differential mode converts three times and returns (first - second) / third.
// - single mode stops after one result, continuous mode repeats until stopped.
// - a readable busy bit is set while a conversion or sequence runs.
// - an enabled interrupt signals completion so that polling is not needed.
// - averaging combines several conversions into one result.
package sas_pkg;
   // sample clock timing
   localparam int CLK_HZ       = 100_000_000;
   localparam int SCLK_HZ      = 4_000_000;
   localparam int SCLK_DIV     = CLK_HZ / SCLK_HZ;
   localparam int CONV_TICKS   = 20;
   localparam int SAMPLE_TICKS = 9;
   localparam int SAMPLE_CYC   = SAMPLE_TICKS * SCLK_DIV;
   localparam int RES_W        = 10;
   localparam int NUM_W        = 2 * RES_W;
   localparam int ACC_W        = RES_W + 7;
   localparam int ADDR_W       = 5;

   localparam logic [4:0] TICK_LAST    = 5'(SCLK_DIV - 1);
   localparam logic [4:0] TCNT_SMP_END = 5'(SAMPLE_TICKS - 1);
   localparam logic [4:0] TCNT_LSB     = 5'(CONV_TICKS - 2);
   localparam logic [4:0] TCNT_LAST    = 5'(CONV_TICKS - 1);
   localparam logic [4:0] DIV_LAST     = 5'(NUM_W - 1);
   localparam logic [9:0] RES_MAX      = 10'h3ff;
   localparam logic [9:0] DAC_MSB      = 10'h200;
   localparam logic [2:0] CHAN_TEMP    = 3'h4;
   localparam logic [2:0] CHAN_SUPPLY  = 3'h5;
   localparam logic [2:0] SCALE_UNITY  = 3'h0;

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFF_CTRL     = 5'h00;
   localparam logic [ADDR_W-1:0] OFF_CHAN     = 5'h04;
   localparam logic [ADDR_W-1:0] OFF_STATUS   = 5'h08;
   localparam logic [ADDR_W-1:0] OFF_RESULT   = 5'h0c;
   localparam logic [ADDR_W-1:0] OFF_RAW      = 5'h10;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 5'h14;
   localparam logic [ADDR_W-1:0] OFF_IRQ_EN   = 5'h18;
   localparam logic [ADDR_W-1:0] OFF_IRQ_CLR  = 5'h1c;

   // field positions
   localparam int CTRL_START     = 0;
   localparam int CTRL_STOP      = 1;
   localparam int CTRL_CONT      = 2;
   localparam int CTRL_MODE_LSB  = 3;
   localparam int CTRL_AVG_LSB   = 5;
   localparam int CHAN_A_LSB     = 0;
   localparam int CHAN_B_LSB     = 4;
   localparam int CHAN_C_LSB     = 8;
   localparam int CHAN_SCALE_LSB = 12;
   localparam int STAT_BUSY      = 0;
   localparam int IRQ_DONE       = 0;

   // reset values
   localparam logic WAIT_RST = 1'b1;

   typedef enum logic [1:0] {MODE_ABS, MODE_RATIO, MODE_DIFF, MODE_RDIFF} sas_mode_e;
   typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_DIV} sas_state_e;

   // analog front-end controls
   typedef struct packed {
      logic [2:0]       sel;
      logic [2:0]       scale;
      logic             sample;
      logic [RES_W-1:0] dac;
   } sas_ana_s;

   typedef struct packed {
      logic             busy;
      logic [4:0]       cnt;
      logic [NUM_W-1:0] num;
      logic [RES_W-1:0] rem;
      logic [RES_W-1:0] den;
      logic             done;
      logic [RES_W-1:0] quo;
   } sas_div_s;

   typedef struct packed {
      sas_state_e       st;
      logic [4:0]       dcnt;
      logic [4:0]       tcnt;
      logic [1:0]       slot;
      logic [6:0]       rep;
      logic [ACC_W-1:0] acc;
      logic [RES_W-1:0] a;
      logic [RES_W-1:0] b;
      logic [RES_W-1:0] c;
      logic             neg;
      logic             div_go;
      logic [15:0]      result;
      logic             cont;
      sas_mode_e        mode;
      logic [2:0]       avg;
      logic [2:0]       ch_a;
      logic [2:0]       ch_b;
      logic [2:0]       ch_c;
      logic [2:0]       scale;
      logic             stat;
      logic             en;
      logic             irq;
      logic             waitreq;
      logic [31:0]      rdata;
      sas_ana_s         ana;
   } sas_top_s;
endpackage

// ==== design/sas_divider.sv ====
`timescale 1ns/1ps
`default_nettype none
module sas_divider
   import sas_pkg::*;
(
   input  wire logic             mclk_i,
   input  wire logic             reset_i,
   input  wire logic             start_i,
   input  wire logic [NUM_W-1:0] num_i,
   input  wire logic [RES_W-1:0] den_i,
   output logic                  done_o,
   output logic [RES_W-1:0]      quo_o
);
   sas_div_s         r;
   sas_div_s         n;
   logic [RES_W:0]   rsh;

   ////////////////////////////////////////////////////////////////////////////
   // restoring division, one quotient bit per cycle; slow but tiny
   always_comb begin
      n = r;
      n.done = 1'b0;
      rsh = {r.rem, r.num[NUM_W-1]};
      if (start_i) begin
         n.busy = 1'b1;
         n.cnt  = '0;
         n.num  = num_i;
         n.rem  = '0;
         n.den  = den_i;
      end else if (r.busy) begin
         if (rsh >= {1'b0, r.den}) begin
            n.rem = RES_W'(rsh - {1'b0, r.den});
            n.num = {r.num[NUM_W-2:0], 1'b1};
         end else begin
            n.rem = RES_W'(rsh);
            n.num = {r.num[NUM_W-2:0], 1'b0};
         end
         n.cnt = r.cnt + 5'h1;
         if (r.cnt == DIV_LAST) begin
            n.busy = 1'b0;
            n.done = 1'b1;
            // a zero divisor or a ratio of one or more saturates to full scale
            if (r.den == '0 || |n.num[NUM_W-1:RES_W]) begin
               n.quo = RES_MAX;
            end else begin
               n.quo = n.num[RES_W-1:0];
            end
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign done_o = r.done;
   assign quo_o  = r.quo;
endmodule
`default_nettype wire

// ==== design/sas_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
module sas_sequencer
   import sas_pkg::*;
(
   input  wire logic              mclk_i,
   input  wire logic              reset_i,
   input  wire logic [ADDR_W-1:0] avs_address_i,
   input  wire logic              avs_read_i,
   input  wire logic              avs_write_i,
   input  wire logic [31:0]       avs_writedata_i,
   output logic [31:0]            avs_readdata_o,
   output logic                   avs_waitrequest_o,
   input  wire logic              cmp_i,
   output sas_ana_s               ana_o,
   output logic                   irq_o
);
   sas_top_s             r;
   sas_top_s             n;
   logic                 tick;
   logic                 wr;
   logic                 clr_w;
   logic                 fin;
   logic                 done_w;
   logic                 conv_end_w;
   logic [3:0]           bidx;
   logic [ACC_W-1:0]     sum;
   logic [RES_W-1:0]     val;
   logic [RES_W:0]       dif;
   logic [RES_W:0]       fdif;
   logic [15:0]          resv;
   logic [31:0]          rd;
   logic [NUM_W-1:0]     div_num;
   logic [RES_W-1:0]     div_den;
   logic                 div_done;
   logic [RES_W-1:0]     div_quo;

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   // index of the last conversion slot of a mode
   function automatic logic [1:0] last_slot(sas_mode_e m);
      case (m)
         MODE_ABS:   return 2'h0;
         MODE_RDIFF: return 2'h2;
         default:    return 2'h1;
      endcase
   endfunction

   // number of repeats minus one for an averaging shift
   function automatic logic [6:0] rep_last(logic [2:0] avg);
      return 7'((8'h1 << avg) - 8'h1);
   endfunction

   // front-end setting that opens a conversion on a channel
   function automatic sas_ana_s open_conv(logic [2:0] ch, logic [2:0] sc);
      sas_ana_s s;
      s.sel    = (ch > CHAN_SUPPLY) ? CHAN_SUPPLY : ch;
      s.scale  = (s.sel < CHAN_TEMP) ? sc : SCALE_UNITY;
      s.sample = 1'b1;
      s.dac    = '0;
      return s;
   endfunction

   function automatic logic [2:0] slot_chan(sas_top_s s, logic [1:0] sl);
      case (sl)
         2'h0:    return s.ch_a;
         2'h1:    return s.ch_b;
         default: return s.ch_c;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // read mux, decoded on the first cycle of a read
   always_comb begin
      rd = '0;
      if (avs_address_i == OFF_CTRL) begin
         rd[CTRL_CONT]                  = r.cont;
         rd[CTRL_MODE_LSB +: 2]         = r.mode;
         rd[CTRL_AVG_LSB +: 3]          = r.avg;
      end else if (avs_address_i == OFF_CHAN) begin
         rd[CHAN_A_LSB +: 3]            = r.ch_a;
         rd[CHAN_B_LSB +: 3]            = r.ch_b;
         rd[CHAN_C_LSB +: 3]            = r.ch_c;
         rd[CHAN_SCALE_LSB +: 3]        = r.scale;
      end else if (avs_address_i == OFF_STATUS) begin
         rd[STAT_BUSY]                  = (r.st != ST_IDLE);
      end else if (avs_address_i == OFF_RESULT) begin
         rd[15:0]                       = r.result;
      end else if (avs_address_i == OFF_RAW) begin
         rd[RES_W-1:0]                  = r.a;
      end else if (avs_address_i == OFF_IRQ_STAT) begin
         rd[IRQ_DONE]                   = r.stat;
      end else if (avs_address_i == OFF_IRQ_EN) begin
         rd[IRQ_DONE]                   = r.en;
      end
   end

   // divider operands come from settled slot results
   assign dif     = {1'b0, r.a} - {1'b0, r.b};
   assign div_num = (r.mode == MODE_RATIO) ? {r.a, 10'h000}
                  : {(dif[RES_W] ? RES_W'(-dif) : dif[RES_W-1:0]), 10'h000};
   assign div_den = (r.mode == MODE_RATIO) ? r.b : r.c;

   sas_divider u_div (
      .mclk_i  (mclk_i),
      .reset_i (reset_i),
      .start_i (r.div_go),
      .num_i   (div_num),
      .den_i   (div_den),
      .done_o  (div_done),
      .quo_o   (div_quo)
   );

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      n = r;
      n.div_go = 1'b0;
      tick = (r.dcnt == TICK_LAST);
      n.dcnt = tick ? 5'h0 : r.dcnt + 5'h1;
      fin = 1'b0;
      done_w = 1'b0;
      conv_end_w = 1'b0;
      bidx = '0;
      sum = '0;
      val = '0;
      resv = '0;
      fdif = '0;

      // bus handshake: one wait cycle, write lands on the release edge
      wr = avs_write_i & ~r.waitreq;
      n.waitreq = ~((avs_read_i | avs_write_i) & r.waitreq);
      if (avs_read_i & r.waitreq) begin
         n.rdata = rd;
      end
      clr_w = wr && avs_address_i == OFF_IRQ_CLR && avs_writedata_i[IRQ_DONE];
      if (wr && avs_address_i == OFF_IRQ_EN) begin
         n.en = avs_writedata_i[IRQ_DONE];
      end
      // stop is honoured anytime; setup only while idle so a run is never torn
      if (wr && avs_address_i == OFF_CTRL && avs_writedata_i[CTRL_STOP]) begin
         n.cont = 1'b0;
      end
      if (wr && r.st == ST_IDLE) begin
         if (avs_address_i == OFF_CTRL) begin
            n.cont = avs_writedata_i[CTRL_CONT] & ~avs_writedata_i[CTRL_STOP];
            n.mode = sas_mode_e'(avs_writedata_i[CTRL_MODE_LSB +: 2]);
            n.avg  = avs_writedata_i[CTRL_AVG_LSB +: 3];
         end else if (avs_address_i == OFF_CHAN) begin
            n.ch_a  = avs_writedata_i[CHAN_A_LSB +: 3];
            n.ch_b  = avs_writedata_i[CHAN_B_LSB +: 3];
            n.ch_c  = avs_writedata_i[CHAN_C_LSB +: 3];
            n.scale = avs_writedata_i[CHAN_SCALE_LSB +: 3];
         end
      end

      case (r.st)
         ST_IDLE: begin
            n.dcnt = 5'h0;
            if (wr && avs_address_i == OFF_CTRL && avs_writedata_i[CTRL_START]) begin
               n.st   = ST_CONV;
               n.tcnt = 5'h0;
               n.slot = 2'h0;
               n.rep  = '0;
               n.acc  = '0;
               n.ana  = open_conv(n.ch_a, n.scale);
            end
         end
         ST_CONV: begin
            if (tick) begin
               n.tcnt = r.tcnt + 5'h1;
               // sample phase ends, trial of the top bit begins
               if (r.tcnt == TCNT_SMP_END) begin
                  n.ana.sample = 1'b0;
                  n.ana.dac    = DAC_MSB;
               end else if (r.tcnt > TCNT_SMP_END && r.tcnt <= TCNT_LSB) begin
                  // keep the trial bit when the input is at or above the dac
                  bidx = 4'(TCNT_LSB - r.tcnt);
                  n.ana.dac[bidx] = cmp_i;
                  if (bidx != 4'h0) begin
                     n.ana.dac[bidx - 4'h1] = 1'b1;
                  end
               end else if (r.tcnt == TCNT_LAST) begin
                  conv_end_w = 1'b1;
                  sum = r.acc + ACC_W'(r.ana.dac);
                  n.tcnt = 5'h0;
                  if (r.rep == rep_last(r.avg)) begin
                     val = RES_W'(sum >> r.avg);
                     case (r.slot)
                        2'h0:    n.a = val;
                        2'h1:    n.b = val;
                        default: n.c = val;
                     endcase
                     n.acc = '0;
                     n.rep = '0;
                     if (r.slot == last_slot(r.mode)) begin
                        fin = 1'b1;
                     end else begin
                        n.slot = r.slot + 2'h1;
                     end
                  end else begin
                     n.acc = sum;
                     n.rep = r.rep + 7'h1;
                  end
                  n.ana = open_conv(slot_chan(n, n.slot), n.scale);
               end
            end
         end
         ST_DIV: begin
            if (div_done) begin
               done_w = 1'b1;
               resv = r.neg ? 16'h0 - {6'h00, div_quo} : {6'h00, div_quo};
            end
         end
         default: n.st = ST_IDLE;
      endcase

      // sequence end: direct results or hand over to the divider
      if (fin) begin
         // the last slot result is only in n here, so the difference is taken again
         fdif = {1'b0, n.a} - {1'b0, n.b};
         if (r.mode == MODE_ABS) begin
            done_w = 1'b1;
            resv = {6'h00, n.a};
         end else if (r.mode == MODE_DIFF) begin
            done_w = 1'b1;
            resv = {{5{fdif[RES_W]}}, fdif};
         end else begin
            n.st = ST_DIV;
            n.div_go = 1'b1;
            n.neg = (r.mode == MODE_RDIFF) && fdif[RES_W];
            n.ana.sample = 1'b0;
         end
      end
      if (done_w) begin
         n.result = resv;
         n.slot = 2'h0;
         if (n.cont) begin
            n.st = ST_CONV;
            n.tcnt = 5'h0;
            n.dcnt = 5'h0;
            n.ana = open_conv(n.ch_a, n.scale);
         end else begin
            n.st = ST_IDLE;
            n.ana.sample = 1'b0;
         end
      end

      // set wins over a clear in the same cycle
      n.stat = (r.stat & ~clr_w) | done_w;
      n.irq = n.stat & n.en;
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         r <= '0;
         r.waitreq <= WAIT_RST;
      end else begin
         r <= n;
      end
   end

   assign avs_readdata_o    = r.rdata;
   assign avs_waitrequest_o = r.waitreq;
   assign ana_o             = r.ana;
   assign irq_o             = r.irq;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   logic [8:0]  smp_cnt;
   logic [8:0]  conv_cnt;
   logic        busy_w;

   assign busy_w = (r.st != ST_IDLE);

   // fast-clock lengths of the sample window and of a whole conversion
   always_ff @(posedge mclk_i) begin
      if (reset_i || !r.ana.sample) begin
         smp_cnt <= '0;
      end else begin
         smp_cnt <= smp_cnt + 9'h1;
      end
      if (reset_i || r.st != ST_CONV || conv_end_w) begin
         conv_cnt <= '0;
      end else begin
         conv_cnt <= conv_cnt + 9'h1;
      end
   end

   default clocking cb_chk @(posedge mclk_i);
   endclocking
   default disable iff (reset_i);

   // a status read opens while the slave still holds off the master
   sequence s_status_open;
      avs_read_i && avs_waitrequest_o && avs_address_i == OFF_STATUS;
   endsequence

   // a clear lands with no completion in the same cycle to outvote it
   sequence s_clear_lands;
      clr_w && !done_w;
   endsequence

   a_sel_in_range: assert property (ana_o.sel <= CHAN_SUPPLY)
      else $error("input select beyond the supply sensor");
   a_scale_unity: assert property (ana_o.sel >= CHAN_TEMP |-> ana_o.scale == SCALE_UNITY)
      else $error("internal sensor selected with a divider scale");
   a_conv_length: assert property (conv_end_w |-> conv_cnt == 9'(CONV_TICKS * SCLK_DIV - 1))
      else $error("conversion length differs from twenty sample ticks");
   a_sample_window: assert property ($fell(ana_o.sample) |-> smp_cnt == 9'(SAMPLE_CYC))
      else $error("sample window length wrong");
   a_busy_read: assert property (s_status_open |=> avs_readdata_o[STAT_BUSY] == $past(busy_w))
      else $error("status read does not show busy");
   a_irq_clear: assert property (s_clear_lands |=> !irq_o && !r.stat)
      else $error("done flag survived its clear");
   a_irq_gated: assert property (irq_o |-> r.en)
      else $error("interrupt raised while disabled");
   a_div_latency: assert property (r.div_go |-> ##21 div_done)
      else $error("divider answer not on time");
endmodule
`default_nettype wire

// ==== tb/sas_analog_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// mux, divider and comparator seen from the sequencer's pins
module sas_analog_model
   import sas_pkg::*;
(
   input  wire logic             mclk_i,
   input  wire sas_ana_s         ana_i,
   input  wire logic [RES_W-1:0] code_i [6],
   input  wire logic             wobble_i,
   output logic                  cmp_o,
   output logic [2:0]            sel_o,
   output logic [2:0]            scale_o,
   output int                    nsmp_o,
   output int                    gap_o
);
   logic [RES_W-1:0] held;
   logic [1:0]       jit;
   logic             smp_q;
   int               settle;
   int               since;
   initial begin
      {held, jit, smp_q, cmp_o, sel_o, scale_o} = '0;
      {settle, since, nsmp_o, gap_o} = '0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // track-and-hold: too short a window leaves the old level held
   always @(posedge mclk_i) begin
      smp_q <= ana_i.sample;
      since <= since + 1;
      settle <= ana_i.sample ? settle + 1 : 0;
      if (ana_i.sample && !smp_q) begin
         nsmp_o <= nsmp_o + 1;
         gap_o <= since;
         since <= 1;
         jit <= wobble_i ? jit + 2'h1 : 2'h0;
         sel_o <= ana_i.sel;
         scale_o <= ana_i.scale;
      end
      if (ana_i.sample && settle >= 112 && ana_i.sel < 3'h6) begin
         held <= code_i[ana_i.sel] + RES_W'(jit);
      end
      // ideal comparator, input at or above the trial level
      cmp_o <= (held >= ana_i.dac);
   end
endmodule
`default_nettype wire

// ==== tb/sas_adc_sequencer_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module sar_adc_sequencer_tb;
   import sas_pkg::*;
   logic              mclk_i;
   logic              reset_i;
   logic [ADDR_W-1:0] avs_address_i;
   logic              avs_read_i;
   logic              avs_write_i;
   logic [31:0]       avs_writedata_i;
   logic [31:0]       avs_readdata_o;
   logic              avs_waitrequest_o;
   logic              cmp;
   sas_ana_s          ana;
   logic              irq_o;
   logic              wobble;
   logic [2:0]        m_sel;
   logic [2:0]        m_scale;
   int                nsmp;
   int                gap;
   int                failures;
   int                checks_done;
   int                cycles;
   logic [RES_W-1:0]  code [6];
   logic [31:0]       v;
   int                n0;
   int                ex;

   sas_sequencer i_dut (.mclk_i(mclk_i), .reset_i(reset_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
      .cmp_i(cmp), .ana_o(ana), .irq_o(irq_o));
   sas_analog_model i_ana (.mclk_i(mclk_i), .ana_i(ana), .code_i(code), .wobble_i(wobble),
      .cmp_o(cmp), .sel_o(m_sel), .scale_o(m_scale), .nsmp_o(nsmp), .gap_o(gap));

   ////////////////////////////////////////////////////////////////////////////////
   // clock, plus a cycle ceiling so a hung handshake still ends the run
   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end
   always @(posedge mclk_i) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         failures++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // one bus cycle; opens an edge after the last release so strobes never double up
   task automatic bus(input logic [4:0] a, input logic wr, input logic [31:0] d,
                      output logic [31:0] r);
      @(posedge mclk_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= wr;
      avs_read_i <= !wr;
      // no local limit: the cycle ceiling ends a wait that is never answered
      do begin
         @(posedge mclk_i);
      end while (avs_waitrequest_o !== 1'b0);
      r = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(a, 1'b1, d, r);
   endtask

   task automatic rd(input logic [4:0] a, output logic [31:0] r);
      bus(a, 1'b0, 32'h0, r);
   endtask

   // poll busy until it drops; the cycle ceiling bounds a hang
   task automatic wait_idle();
      logic [31:0] s;
      do begin
         rd(OFF_STATUS, s);
      end while (s[STAT_BUSY] !== 1'b0);
   endtask

   // start, see busy, wait, compare the result and the sample count
   task automatic conv(input logic [31:0] ctl, input logic [31:0] ch, input int exp,
                       input int smp);
      int n;
      n = nsmp;
      wr(OFF_CHAN, ch);
      wr(OFF_CTRL, ctl | 32'h1);
      rd(OFF_STATUS, v);
      chk(v[STAT_BUSY], 1);
      wait_idle();
      rd(OFF_RESULT, v);
      chk(v[RES_W-1:0], exp[RES_W-1:0]);
      chk(nsmp - n, smp);
      rd(OFF_IRQ_STAT, v);
      chk(v[IRQ_DONE], 1);
      rd(OFF_CHAN, v);
      chk(v[15:0], ch[15:0]);
      rd(OFF_CTRL, v);
      chk(v, ctl);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      code = '{10'h0c8, 10'h2ee, 10'h064, 10'h1f4, 10'h155, 10'h3a0};
      {avs_address_i, avs_read_i, avs_write_i, avs_writedata_i, wobble} = '0;
      {failures, checks_done, cycles} = '0;
      reset_i = 1'b1;
      repeat (5) @(posedge mclk_i);
      reset_i <= 1'b0;
      // idle after reset, one unmapped read to see the bus still answers
      rd(OFF_STATUS, v);
      chk(v[STAT_BUSY], 0);
      rd(OFF_IRQ_STAT, v);
      chk(v[IRQ_DONE], 0);
      rd(5'h02, v);
      $display("test reset done");
      // absolute, every mux source, scale forced to unity on internal sensors
      for (int c = 0; c < 6; c++) begin
         conv(32'h0, (c << CHAN_SCALE_LSB) | c, code[c], 1);
         chk(m_sel, c[2:0]);
         chk(m_scale, c < 4 ? c[2:0] : SCALE_UNITY);
         rd(OFF_RAW, v);
         chk(v[RES_W-1:0], code[c]);
         chk(irq_o, 0);
         wr(OFF_IRQ_CLR, 32'h1);
      end
      $display("test absolute done");
      // multi-conversion modes with the interrupt enabled
      wr(OFF_IRQ_EN, 32'h1);
      rd(OFF_IRQ_EN, v);
      chk(v[IRQ_DONE], 1);
      for (int m = 1; m < 4; m++) begin
         ex = (m == 1) ? (int'(code[0]) * 1024) / code[1] :
              (m == 2) ? code[1] - code[0] :
              ((int'(code[1]) - code[0]) * 1024) / code[5];
         conv(m << CTRL_MODE_LSB,
              m == 1 ? 32'h010 : 32'h501, ex, m == 3 ? 3 : 2);
         chk(irq_o, 1);
         wr(OFF_IRQ_CLR, 32'h1);
         @(posedge mclk_i);
         chk(irq_o, 0);
         rd(OFF_IRQ_STAT, v);
         chk(v[IRQ_DONE], 0);
      end
      $display("test modes done");
      // four samples of base+1, base+2, base+3, base average to base+1
      wobble <= 1'b1;
      conv(2 << CTRL_AVG_LSB, 32'h3, code[3] + 1, 4);
      wobble <= 1'b0;
      wr(OFF_IRQ_CLR, 32'h1);
      $display("test average done");
      // continuous: back-to-back samples one conversion apart, stops on request
      n0 = nsmp;
      wr(OFF_CHAN, 32'h2);
      wr(OFF_CTRL, (1 << CTRL_CONT) | 1);
      for (int i = 0; i < 3000 && nsmp < n0 + 3; i++) @(posedge mclk_i);
      chk(gap, CONV_TICKS * SCLK_DIV);
      rd(OFF_STATUS, v);
      chk(v[STAT_BUSY], 1);
      wr(OFF_CTRL, 1 << CTRL_STOP);
      wait_idle();
      n0 = nsmp;
      repeat (600) @(posedge mclk_i);
      chk(nsmp, n0);
      rd(OFF_RESULT, v);
      chk(v[RES_W-1:0], code[2]);
      $display("test continuous done");
      end_of_test();
   end
endmodule
`default_nettype wire
